// [core/bcdc_counter.sv]
// Four-decade BCD up/down counter with preset sequencer and Avalon-MM registers
//
// How it works
// - Count input rising edge adds one when up, subtracts one when down.
// - Output latches follow the counter while latch update is low.
// - Clear low forces counter to 0000 immediately, no edge needed.
// - Count edges ignored during clear or counter load.
// - Both loads mid: BCD port outputs latch digits, MSD to LSD.
// - Any load high: BCD drivers off, port lines are inputs.
// - Counter load high blocks counting, writes port digits into counter.
// - Register load writes compare register only; both loads preset both.
// - Register load low: oscillator stopped, port and display off, counting continues.
// - Counter load low: BCD port off, counter and register untouched.
// - BCD outputs active high; inputs inverted on common-cathode variant.
// - During loads the scan pin is ignored; oscillator free-runs.
// - External scan sets mux clock phase; digits blanked while it is high.
// - Load inputs sampled each clock; short pulse starts a full four-digit scan.
// - Load start resets oscillator and sequencer to D4, enables preset path.
// - After D1, loads resampled; repeat if high, else resume normal.
// - Clear forces preset data to zero; register load during clear writes zero.
// - Clear leaves the compare register unchanged.
// - Flags are undefined during load windows; during clear zero output is low and no wrap pulse.
// - Wrap pulse on 9999 to 0000 up or 0000 to 9999 down.
// - Match output low when counter equals compare register.
// - Zero output low when counter holds 0000.
// - Multiplex steps digits from D4 down to D1.
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
module bcdc_counter
#(
   parameter int SCAN_CYCLES_P = bcdc_pkg::SCAN_CYCLES,
   parameter int BLANK_CYCLES_P = bcdc_pkg::BLANK_CYCLES,
   parameter bit COMMON_CATHODE = 1'b0
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic count_in,
   input wire logic scan_in,
   input wire logic scan_overdrive,
   input wire logic [3:0] bcd_in,
   output logic [3:0] bcd_out,
   output logic bcd_oe,
   output logic [6:0] seg_out,
   output logic msd_digit_strobe,
   output logic digit3_strobe,
   output logic digit2_strobe,
   output logic lsd_digit_strobe,
   output logic wrap_pulse,
   output logic match_n,
   output logic zero_n
);
   import bcdc_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // decimal step
   function automatic logic [16:0] bcd_step(input logic [15:0] v, input logic up);
      logic [15:0] r;
      logic c;
      r = v;
      c = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         if (c)
         begin
            if (up)
            begin
               c = (v[i*4 +: 4] == DIGIT_NINE);
               r[i*4 +: 4] = c ? 4'h0 : v[i*4 +: 4] + 4'h1;
            end
            else
            begin
               c = (v[i*4 +: 4] == 4'h0);
               r[i*4 +: 4] = c ? DIGIT_NINE : v[i*4 +: 4] - 4'h1;
            end
         end
      end
      return {c, r};
   endfunction

   function automatic logic [6:0] seg_decode(input logic [3:0] d);
      logic [6:0] s;
      case (d)
         4'h0: s = 7'h3F;
         4'h1: s = 7'h06;
         4'h2: s = 7'h5B;
         4'h3: s = 7'h4F;
         4'h4: s = 7'h66;
         4'h5: s = 7'h6D;
         4'h6: s = 7'h7D;
         4'h7: s = 7'h07;
         4'h8: s = 7'h7F;
         4'h9: s = 7'h6F;
         default: s = 7'h00;
      endcase
      return s;
   endfunction

   // ----------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------
   logic [6:0] ctrl;
   logic [15:0] counter;
   logic [15:0] compare;
   logic [15:0] latch;
   logic ack;
   logic count_prev;
   logic scan_prev;
   logic [31:0] osc_cnt;
   logic [1:0] digit;
   bcdc_state_t state;
   logic req_cnt;
   logic req_reg;
   logic tgt_cnt;
   logic tgt_reg;

   logic up;
   logic latch_n;
   logic clear;
   bcdc_lvl_t lc;
   bcdc_lvl_t lr;
   logic loading;
   logic display_off;
   logic osc_tick;
   logic osc_blank;
   logic mux_tick;
   logic blank;
   logic count_edge;
   logic [15:0] counter_view;
   logic [3:0] preset_digit;
   logic [16:0] stepped;

   assign up = ctrl[CTRL_UP_BIT];
   assign latch_n = ctrl[CTRL_LATCH_N_BIT];
   assign clear = ~ctrl[CTRL_CLEAR_N_BIT];
   assign lc = bcdc_lvl_t'(ctrl[CTRL_LC_LSB +: 2]);
   assign lr = bcdc_lvl_t'(ctrl[CTRL_LR_LSB +: 2]);
   assign loading = (state == ST_LOAD);
   assign display_off = (lr == LVL_LOW);
   // clear acts at once on what is seen
   assign counter_view = clear ? VALUE_ZERO : counter;

   // ----------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------
   // One wait cycle: read data registered on the first edge, write taken on the second
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         ack <= 1'b0;
      else
         ack <= (avs_read | avs_write) & ~ack;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read && !ack)
      begin
         if (avs_address == ADDR_CTRL)
            avs_readdata <= {25'h0, ctrl};
         else if (avs_address == ADDR_COUNT)
            avs_readdata <= {16'h0, counter_view};
         else if (avs_address == ADDR_COMPARE)
            avs_readdata <= {16'h0, compare};
         else if (avs_address == ADDR_LATCH)
            avs_readdata <= {16'h0, latch};
         else if (avs_address == ADDR_STATUS)
            avs_readdata <= {29'h0, ~zero_n, ~match_n, loading};
         else
            avs_readdata <= 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         ctrl <= CTRL_RESET;
      else if (avs_write && ack && avs_address == ADDR_CTRL)
         ctrl <= avs_writedata[6:0];
   end

   // ----------------------------------------------------------------
   // Scan oscillator and digit sequencer
   // ----------------------------------------------------------------
   assign osc_tick = (osc_cnt == 32'(SCAN_CYCLES_P - 1));
   assign osc_blank = (osc_cnt < 32'(BLANK_CYCLES_P));
   assign mux_tick = (scan_overdrive && !loading) ? (scan_in && !scan_prev) : osc_tick;
   assign blank = (scan_overdrive && !loading) ? scan_in : osc_blank;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         scan_prev <= 1'b0;
      else
         scan_prev <= scan_in;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         osc_cnt <= 32'h0;
      else if (!loading && (req_cnt || req_reg))
         osc_cnt <= 32'h0;
      else if (display_off && !loading)
         osc_cnt <= 32'h0;
      else if (osc_tick)
         osc_cnt <= 32'h0;
      else
         osc_cnt <= osc_cnt + 32'h1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         digit <= DIGIT_MSD;
      else if (!loading && (req_cnt || req_reg))
         digit <= DIGIT_MSD;
      else if (display_off && !loading)
         digit <= DIGIT_MSD;
      else if (mux_tick)
         digit <= digit - 2'h1;
   end

   // ----------------------------------------------------------------
   // Preset sequencer
   // ----------------------------------------------------------------
   // any high cycle outside a load starts one
   // Consumed on entry, else a held level would force a second pass
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         req_cnt <= 1'b0;
         req_reg <= 1'b0;
      end
      else
      begin
         req_cnt <= !loading && (lc == LVL_HIGH);
         req_reg <= !loading && (lr == LVL_HIGH);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state <= ST_RUN;
         tgt_cnt <= 1'b0;
         tgt_reg <= 1'b0;
      end
      else
      begin
         case (state)
            ST_RUN:
            begin
               if (req_cnt || req_reg)
               begin
                  state <= ST_LOAD;
                  tgt_cnt <= req_cnt;
                  tgt_reg <= req_reg;
               end
            end
            ST_LOAD:
            begin
               if (mux_tick && digit == DIGIT_LSD)
               begin
                  tgt_cnt <= req_cnt || (lc == LVL_HIGH);
                  tgt_reg <= req_reg || (lr == LVL_HIGH);
                  if (!(req_cnt || req_reg || lc == LVL_HIGH || lr == LVL_HIGH))
                     state <= ST_RUN;
               end
            end
            default:
               state <= ST_RUN;
         endcase
      end
   end

   // clear forces preset data to zero
   assign preset_digit = clear ? 4'h0 : (COMMON_CATHODE ? ~bcd_in : bcd_in);

   // ----------------------------------------------------------------
   // Counter, compare register, latches
   // ----------------------------------------------------------------
   assign count_edge = count_in && !count_prev;
   assign stepped = bcd_step(counter, up);

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         count_prev <= 1'b0;
      else
         count_prev <= count_in;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         counter <= VALUE_ZERO;
      else if (clear)
         counter <= VALUE_ZERO;
      // digit written at strobe trailing edge
      else if (loading && tgt_cnt && mux_tick)
         counter[digit*4 +: 4] <= preset_digit;
      else if (count_edge && !(loading && tgt_cnt))
         counter <= stepped[15:0];
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         compare <= VALUE_ZERO;
      else if (loading && tgt_reg && mux_tick)
         compare[digit*4 +: 4] <= preset_digit;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         latch <= VALUE_ZERO;
      else if (!latch_n)
         latch <= counter_view;
   end

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   // flags undefined in load windows, so match and zero are not masked
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         wrap_pulse <= 1'b0;
      else
         wrap_pulse <= count_edge && !clear && !(loading && tgt_cnt) && stepped[16];
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         match_n <= 1'b0;
         zero_n <= 1'b0;
      end
      else
      begin
         match_n <= !(counter_view == compare);
         zero_n <= !(counter_view == VALUE_ZERO);
      end
   end

   // ----------------------------------------------------------------
   // Display and BCD port
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         bcd_out <= 4'h0;
         bcd_oe <= 1'b0;
         seg_out <= 7'h00;
         msd_digit_strobe <= 1'b0;
         digit3_strobe <= 1'b0;
         digit2_strobe <= 1'b0;
         lsd_digit_strobe <= 1'b0;
      end
      else
      begin
         // latch digit out when both mid
         bcd_out <= latch[digit*4 +: 4];
         bcd_oe <= (lc == LVL_MID) && (lr == LVL_MID) && !loading;
         seg_out <= (display_off || blank) ? 7'h00 : seg_decode(latch[digit*4 +: 4]);
         msd_digit_strobe <= !display_off && !blank && digit == DIGIT_MSD;
         digit3_strobe <= !display_off && !blank && digit == 2'h2;
         digit2_strobe <= !display_off && !blank && digit == 2'h1;
         lsd_digit_strobe <= !display_off && !blank && digit == DIGIT_LSD;
      end
   end
endmodule

// [core/bcdc_pkg.sv]
// Constants and types for the four-decade BCD up/down counter
package bcdc_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int SCAN_PERIOD_NS = 100000;
   localparam int SCAN_CYCLES = SCAN_PERIOD_NS / CLK_PERIOD_NS;
   // Oscillator duty of about 25:1 gives the inter-digit blank
   localparam int SCAN_DUTY_DIV = 26;
   localparam int BLANK_CYCLES = (SCAN_CYCLES / SCAN_DUTY_DIV > 0) ? SCAN_CYCLES / SCAN_DUTY_DIV : 1;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_COUNT = 5'h04;
   localparam logic [4:0] ADDR_COMPARE = 5'h08;
   localparam logic [4:0] ADDR_LATCH = 5'h0C;
   localparam logic [4:0] ADDR_STATUS = 5'h10;

   localparam int CTRL_UP_BIT = 0;
   localparam int CTRL_LATCH_N_BIT = 1;
   localparam int CTRL_CLEAR_N_BIT = 2;
   localparam int CTRL_LC_LSB = 3;
   localparam int CTRL_LR_LSB = 5;
   localparam int STAT_LOADING_BIT = 0;
   localparam int STAT_MATCH_BIT = 1;
   localparam int STAT_ZERO_BIT = 2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      LVL_LOW = 2'h0,
      LVL_MID = 2'h1,
      LVL_HIGH = 2'h2
   } bcdc_lvl_t;

   typedef enum logic {
      ST_RUN = 1'b0,
      ST_LOAD = 1'b1
   } bcdc_state_t;

   localparam logic [6:0] CTRL_RESET = 7'h2F;
   localparam logic [15:0] VALUE_ZERO = 16'h0000;
   localparam logic [15:0] VALUE_ALL_NINE = 16'h9999;
   localparam logic [3:0] DIGIT_NINE = 4'h9;
   localparam logic [1:0] DIGIT_MSD = 2'h3;
   localparam logic [1:0] DIGIT_LSD = 2'h0;
endpackage

// [testbench/bcdc_chk.sv]
// Port assertions for the BCD counter
`timescale 1ns/100ps
module bcdc_chk
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic count_in,
   input wire logic bcd_oe,
   input wire logic [6:0] seg_out,
   input wire logic msd_digit_strobe,
   input wire logic digit3_strobe,
   input wire logic digit2_strobe,
   input wire logic lsd_digit_strobe,
   input wire logic wrap_pulse,
   input wire logic zero_n
);
   import bcdc_pkg::*;
   // ------------------------------------------------
   // Shadow of control word
   // ------------------------------------------------
   logic [6:0] ctrl;
   logic cnt_prev;
   logic [3:0] since_rise;
   logic [1:0] last_dig;
   wire logic [3:0] strb = {msd_digit_strobe, digit3_strobe, digit2_strobe, lsd_digit_strobe};
   wire logic lr_low = ctrl[6:5] == LVL_LOW;
   wire logic lc_low = ctrl[4:3] == LVL_LOW;
   wire logic not_mid = ctrl[6:5] != LVL_MID || ctrl[4:3] != LVL_MID;
   wire logic clr_low = !ctrl[CTRL_CLEAR_N_BIT];
   always_ff @(posedge clk_sys)
      if (!rst_n)
         ctrl <= CTRL_RESET;
      else if (avs_write && !avs_waitrequest && avs_address == ADDR_CTRL)
         ctrl <= avs_writedata[6:0];
   // Saturating age of the last count edge
   always_ff @(posedge clk_sys)
   begin
      cnt_prev <= rst_n && count_in;
      if (!rst_n)
         since_rise <= 4'hF;
      else if (count_in && !cnt_prev)
         since_rise <= 4'h0;
      else if (since_rise != 4'hF)
         since_rise <= since_rise + 4'h1;
   end
   always_ff @(posedge clk_sys)
      if (!rst_n)
         last_dig <= 2'h0;
      else if (strb != 4'h0)
         last_dig <= strb[3] ? 2'h3 : strb[2] ? 2'h2 : strb[1] ? 2'h1 : 2'h0;
   // ------------------------------------------------
   // Assertions
   // ------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Write lands a cycle or two before outputs follow
   sequence s_held3(b);
      b [*3];
   endsequence
   digit_onehot_a: assert property ($onehot0(strb))
      else $error("several digit strobes high");
   digit_order_a: assert property (($rose(digit3_strobe) |-> last_dig == 2'h3) and
      ($rose(digit2_strobe) |-> last_dig == 2'h2) and ($rose(lsd_digit_strobe) |-> last_dig == 2'h1))
      else $error("digit strobes out of order");
   port_release_a: assert property (s_held3(not_mid) |-> !bcd_oe)
      else $error("port driven with a load level off mid");
   lc_off_a: assert property (s_held3(lc_low) |-> !bcd_oe)
      else $error("port driven with counter load low");
   display_off_a: assert property (s_held3(lr_low) |-> strb == 4'h0 && seg_out == 7'h00)
      else $error("display active while off");
   clear_zero_a: assert property (s_held3(clr_low) |-> !zero_n)
      else $error("zero flag high during clear");
   clear_nowrap_a: assert property (s_held3(clr_low) |-> !wrap_pulse)
      else $error("wrap during clear");
   wrap_cause_a: assert property (wrap_pulse |-> since_rise <= 4'h3)
      else $error("wrap without a count edge");
   wrap_width_a: assert property (wrap_pulse |=> !wrap_pulse)
      else $error("wrap pulse too long");
endmodule
bind bcdc_counter bcdc_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .count_in(count_in), .bcd_oe(bcd_oe), .seg_out(seg_out), .msd_digit_strobe(msd_digit_strobe),
   .digit3_strobe(digit3_strobe), .digit2_strobe(digit2_strobe), .lsd_digit_strobe(lsd_digit_strobe),
   .wrap_pulse(wrap_pulse), .zero_n(zero_n));

// [testbench/bcdc_thumb.sv]
// Thumbwheel preset switch model on the BCD port
`timescale 1ns/100ps
module bcdc_thumb
(
   input wire logic [15:0] preset_val,
   input wire logic msd_digit_strobe,
   input wire logic digit3_strobe,
   input wire logic digit2_strobe,
   input wire logic lsd_digit_strobe,
   input wire logic [3:0] bcd_out,
   input wire logic bcd_oe,
   output logic [3:0] bcd_in
);
   logic [3:0] sw;
   // strobe gated switches
   // Open contacts read 0000 via the pull-downs
   always_comb
   begin
      sw = 4'h0;
      if (msd_digit_strobe)
         sw = preset_val[15:12];
      else if (digit3_strobe)
         sw = preset_val[11:8];
      else if (digit2_strobe)
         sw = preset_val[7:4];
      else if (lsd_digit_strobe)
         sw = preset_val[3:0];
   end
   // Device drive wins while enabled
   assign bcd_in = bcd_oe ? bcd_out : sw;
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the BCD counter
`timescale 1ns/100ps
module testbench;
   import bcdc_pkg::*;
   logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, count_in, scan_in, scan_overdrive;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] bcd_in, bcd_out;
   logic [6:0] seg_out;
   logic bcd_oe, msd_digit_strobe, digit3_strobe, digit2_strobe, lsd_digit_strobe;
   logic wrap_pulse, match_n, zero_n;
   logic [15:0] preset_val;
   int n_fail, cmp_count, wraps;
   wire [3:0] strb = {msd_digit_strobe, digit3_strobe, digit2_strobe, lsd_digit_strobe};
   // Short digit time keeps a load at 160 clocks
   bcdc_counter #(.SCAN_CYCLES_P(40), .BLANK_CYCLES_P(2), .COMMON_CATHODE(1'b0)) dut (.clk_sys(clk_sys),
      .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .count_in(count_in), .scan_in(scan_in), .scan_overdrive(scan_overdrive), .bcd_in(bcd_in),
      .bcd_out(bcd_out), .bcd_oe(bcd_oe), .seg_out(seg_out), .msd_digit_strobe(msd_digit_strobe),
      .digit3_strobe(digit3_strobe), .digit2_strobe(digit2_strobe), .lsd_digit_strobe(lsd_digit_strobe),
      .wrap_pulse(wrap_pulse), .match_n(match_n), .zero_n(zero_n));
   bcdc_thumb u_thumb (.preset_val(preset_val), .msd_digit_strobe(msd_digit_strobe),
      .digit3_strobe(digit3_strobe), .digit2_strobe(digit2_strobe), .lsd_digit_strobe(lsd_digit_strobe),
      .bcd_out(bcd_out), .bcd_oe(bcd_oe), .bcd_in(bcd_in));
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
      if (wrap_pulse === 1'b1)
         wraps <= wraps + 1;
   // ------------------------------------------------
   // Shared tasks
   // ------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= !rd;
      // Waitrequest sampled at the rising edge; only the watchdog ends a wait
      do
      begin
         @(posedge clk_sys);
      end
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] d);
      logic [31:0] q;
      bus(1'b0, ADDR_CTRL, d, q);
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b1, a, 32'h0, q);
      check(q, e);
   endtask
   task automatic pulse(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         count_in <= 1'b1;
         repeat (2) @(posedge clk_sys);
         count_in <= 1'b0;
         repeat (3) @(posedge clk_sys);
      end
   endtask
   // Pulse a load field high, return it to mid, wait
   task automatic load(input logic [31:0] hi, input logic [31:0] back, input logic [15:0] v);
      logic [31:0] s;
      preset_val <= v;
      wr(hi);
      wr(back);
      do
      begin
         bus(1'b1, ADDR_STATUS, 32'h0, s);
      end
      while (s[STAT_LOADING_BIT] !== 1'b0);
   endtask
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_reset();
      rd_chk(ADDR_CTRL, 32'h2F);
      rd_chk(ADDR_COUNT, 32'h0);
      rd_chk(5'h14, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_load();
      scan_overdrive <= 1'b1;
      scan_in <= 1'b1;
      fork
         load(32'h37, 32'h2F, 16'h9998);
         pulse(3);
      join
      scan_overdrive <= 1'b0;
      scan_in <= 1'b0;
      rd_chk(ADDR_COUNT, 32'h9998);
      rd_chk(ADDR_COMPARE, 32'h0);
      $display("test load done");
   endtask
   task automatic t_wrap();
      int w0;
      pulse(1);
      rd_chk(ADDR_COUNT, 32'h9999);
      w0 = wraps;
      pulse(1);
      rd_chk(ADDR_COUNT, 32'h0);
      check(wraps, w0 + 1);
      wr(32'h2E);
      pulse(1);
      rd_chk(ADDR_COUNT, 32'h9999);
      check(wraps, w0 + 2);
      wr(32'h2F);
      $display("test wrap done");
   endtask
   task automatic t_both();
      load(32'h57, 32'h2F, 16'h1234);
      rd_chk(ADDR_COUNT, 32'h1234);
      rd_chk(ADDR_COMPARE, 32'h1234);
      check(match_n, 1'b0);
      load(32'h4F, 32'h2F, 16'h0042);
      rd_chk(ADDR_COMPARE, 32'h0042);
      rd_chk(ADDR_COUNT, 32'h1234);
      check(match_n, 1'b1);
      $display("test both done");
   endtask
   task automatic t_clear();
      wr(32'h2A);
      rd_chk(ADDR_COUNT, 32'h0);
      pulse(1);
      rd_chk(ADDR_COUNT, 32'h0);
      check(zero_n, 1'b0);
      rd_chk(ADDR_COMPARE, 32'h0042);
      load(32'h4A, 32'h2A, 16'h5555);
      rd_chk(ADDR_COMPARE, 32'h0);
      wr(32'h2F);
      pulse(1);
      rd_chk(ADDR_COUNT, 32'h1);
      check(zero_n, 1'b1);
      $display("test clear done");
   endtask
   task automatic t_latch();
      rd_chk(ADDR_LATCH, 32'h0);
      wr(32'h2D);
      wr(32'h2F);
      pulse(1);
      rd_chk(ADDR_LATCH, 32'h1);
      while (lsd_digit_strobe !== 1'b1)
      begin
         @(negedge clk_sys);
      end
      repeat (2) @(negedge clk_sys);
      check(bcd_oe, 1'b1);
      check(bcd_out, 4'h1);
      check(seg_out, 7'h06);
      $display("test latch done");
   endtask
   task automatic t_dark();
      wr(32'h07);
      pulse(1);
      rd_chk(ADDR_COUNT, 32'h3);
      check(strb, 4'h0);
      wr(32'h27);
      repeat (2) @(negedge clk_sys);
      check(bcd_oe, 1'b0);
      wr(32'h2F);
      scan_overdrive <= 1'b1;
      scan_in <= 1'b1;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      check(strb, 4'h0);
      scan_overdrive <= 1'b0;
      scan_in <= 1'b0;
      $display("test dark done");
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (30000) @(posedge clk_sys);
      n_fail++;
      finish_test();
   end
   initial
   begin
      n_fail = 0;
      cmp_count = 0;
      wraps = 0;
      {avs_read, avs_write, count_in, scan_in, scan_overdrive} = 5'h00;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      preset_val = 16'h0;
      rst_n = 1'b0;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset();
      t_load();
      t_wrap();
      t_both();
      t_clear();
      t_latch();
      t_dark();
      finish_test();
   end
endmodule
